// ===== rtl/port_regs.sv
`timescale 1ns/10ps
`include "port_regs_regs.svh"
// Operation
// - Ports 4 and 5 thresholds share one register, port 5 high byte, reset all ones.
// - Ports 6 and 7 thresholds share one register, port 7 high byte.
// - The delineation event status returns its flags on a read and then clears them.
// - Bits 7 to 0 flag delineation-loss start per port, bits 15 to 8 flag its end.
// - Each port timer preloads with 128 times the 15-bit field in bits 15 to 1.
// - An expiring timer sets its status flag, and bit 0 of the timer register disables it.
// - Top source bits 3 to 10 are high while the matching port source is nonzero.
// - Top source bit 2 reports a pending clock-recovery FIFO overflow.
// - Top source bit 1 reports a pending clock-recovery synchronisation error.
// - Top source bit 0 reports a pending clock-recovery parity error.
// - Reading the top source never clears it; bits follow their underlying sources.
// - Mask bits sit at the source positions, 1 masks, all eleven reset masked.
// - Power down stops clock-recovery reception, errors and parity checking.
// - Soft reset is written as 1, self-clears, and always reads as 0.
// - Four independent loopback enables, active high.
module port_regs (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [13:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic [7:0]  lcd_start_in,
  input  wire logic [7:0]  lcd_end_in,
  input  wire logic [7:0]  lcd_active_in,
  input  wire logic [7:0]  port_src_pending_in,
  input  wire port_regs_pkg::rec_err_t rec_err_in,
  input  wire logic        rec_srst_done_in,
  output logic      [7:0]  thr_port_out [8],
  output port_regs_pkg::rec_conf_t rec_conf_out,
  output logic             rec_rx_en_out,
  output logic             rec_par_check_en_out,
  output logic             rec_par_invert_out,
  output logic             high_rate_clock_mode_out,
  output logic             irq_out
);

  logic [15:0] thr45_ff;
  logic [15:0] thr67_ff;
  logic [15:0] lcd_stat_ff;
  logic [15:0] lcd_timer_ff;
  logic [10:0] top_mask_ff;
  port_regs_pkg::rec_conf_t conf_ff;
  port_regs_pkg::rec_err_t  err_pend_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_en_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [7:0]  expire;
  logic [10:0] top_src;
  logic        req;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic [15:0] wmask;
  logic [2:0]  irq_evt;

  // Bus decode: one access per request, ack lasts a single cycle
  assign req   = wb_cyc_in && wb_stb_in && !ack_ff;
  assign wr    = req && wb_we_in;
  assign rd    = req && !wb_we_in;
  assign idx   = wb_adr_in[13:2];
  assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wb_ack_out = ack_ff;
  assign wb_dat_out = dat_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Threshold registers with byte lanes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      thr45_ff <= `RST_THR;
      thr67_ff <= `RST_THR;
    end else if (wr && idx == `IDX_THR45) begin
      thr45_ff <= (thr45_ff & ~wmask) | (wb_dat_in[15:0] & wmask);
    end else if (wr && idx == `IDX_THR67) begin
      thr67_ff <= (thr67_ff & ~wmask) | (wb_dat_in[15:0] & wmask);
    end
  end

  // Upper byte is the odd port, lower byte the even port
  always_comb begin
    thr_port_out[0] = `THR_UNUSED;
    thr_port_out[1] = `THR_UNUSED;
    thr_port_out[2] = `THR_UNUSED;
    thr_port_out[3] = `THR_UNUSED;
    thr_port_out[4] = thr45_ff[7:0];
    thr_port_out[5] = thr45_ff[15:8];
    thr_port_out[6] = thr67_ff[7:0];
    thr_port_out[7] = thr67_ff[15:8];
  end

  // Timer configuration register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lcd_timer_ff <= `RST_LCD_TIMER;
    end else if (wr && idx == `IDX_LCD_TIMER) begin
      lcd_timer_ff <= (lcd_timer_ff & ~wmask) | (wb_dat_in[15:0] & wmask);
    end
  end

  // One delineation timer per port; it arms while idle or disabled and fires once per loss
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lcd
      logic [`LCD_CNT_W-1:0] cnt_ff;
      logic                  run_ff;
      logic [`LCD_CNT_W-1:0] preload;
      assign preload = {lcd_timer_ff[15:1], 7'h00};
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          cnt_ff <= '1;
          run_ff <= 1'b0;
        end else if (lcd_timer_ff[`LCD_DIS_BIT] || !lcd_active_in[gi]) begin
          cnt_ff <= preload;
          run_ff <= 1'b1;
        end else if (run_ff && cnt_ff == '0) begin
          run_ff <= 1'b0;
        end else if (run_ff) begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
      assign expire[gi] = run_ff && cnt_ff == '0 && lcd_active_in[gi]
                          && !lcd_timer_ff[`LCD_DIS_BIT];
    end
  endgenerate

  // Event flags: a new event wins over the clear by read
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lcd_stat_ff <= 16'h0000;
    end else begin
      lcd_stat_ff <= ((rd && idx == `IDX_LCD_STAT) ? 16'h0000 : lcd_stat_ff)
                     | {lcd_end_in, lcd_start_in | expire};
    end
  end

  // Mask register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      top_mask_ff <= `RST_TOP_MASK;
    end else if (wr && idx == `IDX_TOP_MASK) begin
      top_mask_ff <= (top_mask_ff & ~wmask[10:0]) | (wb_dat_in[10:0] & wmask[10:0]);
    end
  end

  // Clock recovery configuration; soft reset clears on completion
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conf_ff <= port_regs_pkg::rec_conf_t'(`RST_INTERNAL_CLOCK_RECOVERY_CIRCUIT_CONF);
    end else if (wr && idx == `IDX_REC_CONF) begin
      conf_ff <= port_regs_pkg::rec_conf_t'(
        ((conf_ff & ~wmask) | (wb_dat_in[15:0] & wmask)) & `REC_WMASK);
    end else if (rec_srst_done_in) begin
      conf_ff.srst <= 1'b0;
    end
  end

  // Pending clock recovery errors; cleared by reading the interrupt status register
  always_ff @(posedge clk_in) begin
    if (srst_in || conf_ff.srst) begin
      err_pend_ff <= '0;
    end else begin
      err_pend_ff <= ((rd && idx == `IDX_IRQ_STAT) ? 3'h0 : err_pend_ff)
                     | (conf_ff.pdn ? 3'h0 : rec_err_in);
    end
  end

  // Top-level summary, not cleared by its own read
  assign top_src = {port_src_pending_in,
                    err_pend_ff.fifo_ovf,
                    err_pend_ff.sync_err,
                    err_pend_ff.par_err};

  // Clock recovery control outputs
  assign rec_conf_out             = conf_ff;
  assign rec_rx_en_out            = !conf_ff.pdn;
  assign rec_par_check_en_out     = !conf_ff.pdn;
  assign rec_par_invert_out       = conf_ff.parc;
  assign high_rate_clock_mode_out = !conf_ff.gim;

  // Interrupt block: sticky status per event group, enable, write-one clear
  assign irq_evt = {|(lcd_start_in | lcd_end_in | expire),
                    |(port_src_pending_in & ~top_mask_ff[10:3]),
                    |(err_pend_ff & ~top_mask_ff[2:0])};
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_stat_ff <= 3'h0;
      irq_en_ff   <= 3'h0;
    end else begin
      irq_stat_ff <= ((wr && idx == `IDX_IRQ_CLR) ? irq_stat_ff & ~wb_dat_in[2:0]
                                                  : irq_stat_ff) | irq_evt;
      if (wr && idx == `IDX_IRQ_EN) begin
        irq_en_ff <= wb_dat_in[2:0];
      end
    end
  end
  assign irq_out = |(irq_stat_ff & irq_en_ff);

  // Read data mux
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dat_ff <= 32'h00000000;
    end else if (rd) begin
      case (idx)
        `IDX_THR45:     dat_ff <= {16'h0000, thr45_ff};
        `IDX_THR67:     dat_ff <= {16'h0000, thr67_ff};
        `IDX_LCD_STAT:  dat_ff <= {16'h0000, lcd_stat_ff};
        `IDX_LCD_TIMER: dat_ff <= {16'h0000, lcd_timer_ff};
        `IDX_TOP_SRC:   dat_ff <= {21'h000000, top_src};
        `IDX_TOP_MASK:  dat_ff <= {21'h000000, top_mask_ff};
        `IDX_REC_CONF:  dat_ff <= {16'h0000, conf_ff & ~`REC_SRST_HIDE};
        `IDX_IRQ_STAT:  dat_ff <= {29'h00000000, irq_stat_ff};
        `IDX_IRQ_EN:    dat_ff <= {29'h00000000, irq_en_ff};
        default:        dat_ff <= 32'h00000000;
      endcase
    end
  end

  // Reference count of enabled cycles in delineation loss on the watched port
  logic [`LCD_CNT_W-1:0] act_cnt_ff;
  logic [`LCD_CNT_W-1:0] load_ff;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      act_cnt_ff <= '0;
      load_ff    <= '0;
    end else if (lcd_timer_ff[`LCD_DIS_BIT] || !lcd_active_in[`LCD_CHK_PORT]) begin
      act_cnt_ff <= '0;
      load_ff    <= `LCD_CNT_W'(lcd_timer_ff[15:1]) << `LCD_SCALE_SH;
    end else if (act_cnt_ff != '1) begin
      act_cnt_ff <= act_cnt_ff + 1'b1;
    end
  end

  // Threshold registers: reset value and full-word writes
  thr_reset_a: assert property (@(posedge clk_in) $past(srst_in) |-> thr45_ff == `RST_THR)
    else $error("threshold 4/5 not reset");

  thr67_rst_a: assert property (@(posedge clk_in) $past(srst_in) |-> thr67_ff == `RST_THR)
    else $error("threshold 6/7 not reset");

  thr_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_THR45 && wb_sel_in == 4'hF |=> thr45_ff == $past(wb_dat_in[15:0]))
    else $error("threshold 4/5 write lost");

  thr67_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_THR67 && wb_sel_in == 4'hF |=> thr67_ff == $past(wb_dat_in[15:0]))
    else $error("threshold 6/7 write lost");

  // Delineation status: read clear and event capture
  stat_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx == `IDX_LCD_STAT && lcd_start_in == 8'h00 && lcd_end_in == 8'h00 && expire == 8'h00
    |=> lcd_stat_ff == 16'h0000) else $error("status not cleared by read");

  stat_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx == `IDX_LCD_STAT |=> wb_dat_out[15:0] == $past(lcd_stat_ff))
    else $error("status read data wrong");

  start_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    lcd_start_in[7] |=> lcd_stat_ff[7]) else $error("start flag lost");

  end_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    lcd_end_in[1] |=> lcd_stat_ff[9]) else $error("end flag lost");

  // Delineation timer: configuration, expiry flag and count length
  timer_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_LCD_TIMER && wb_sel_in == 4'hF |=> lcd_timer_ff == $past(wb_dat_in[15:0]))
    else $error("timer config write lost");

  expire_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
    expire[`LCD_CHK_PORT] |=> lcd_stat_ff[`LCD_CHK_PORT]) else $error("expiry flag lost");

  timer_count_a: assert property (@(posedge clk_in) disable iff (srst_in)
    expire[`LCD_CHK_PORT] |-> act_cnt_ff == load_ff)
    else $error("timer length wrong");

  // Top-level summary and clock recovery pending bits
  top_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx == `IDX_TOP_SRC |=> wb_dat_out[10:3] == $past(port_src_pending_in))
    else $error("summary mismatch");

  src_keep_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx == `IDX_TOP_SRC && !conf_ff.srst |=> (err_pend_ff & $past(err_pend_ff)) == $past(err_pend_ff))
    else $error("summary cleared by its read");

  fifo_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rec_err_in.fifo_ovf && !conf_ff.pdn && !conf_ff.srst |=> err_pend_ff.fifo_ovf)
    else $error("overflow not pending");

  sync_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rec_err_in.sync_err && !conf_ff.pdn && !conf_ff.srst |=> err_pend_ff.sync_err)
    else $error("sync error not pending");

  par_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rec_err_in.par_err && !conf_ff.pdn && !conf_ff.srst |=> err_pend_ff.par_err)
    else $error("parity error not pending");

  // Mask register
  mask_reset_a: assert property (@(posedge clk_in) $past(srst_in) |-> top_mask_ff == `RST_TOP_MASK)
    else $error("mask not reset");

  mask_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_TOP_MASK && wb_sel_in == 4'hF |=> top_mask_ff == $past(wb_dat_in[10:0]))
    else $error("mask write lost");

  // Clock recovery configuration
  pdn_err_a: assert property (@(posedge clk_in) disable iff (srst_in)
    conf_ff.pdn && $past(conf_ff.pdn) && $past(err_pend_ff) == 3'h0 && !conf_ff.srst
    |-> err_pend_ff == 3'h0) else $error("error while powered down");

  pdn_rx_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_REC_CONF && wb_sel_in == 4'hF |=> rec_rx_en_out == !$past(wb_dat_in[5]))
    else $error("reception enable wrong");

  srst_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx == `IDX_REC_CONF |=> !wb_dat_out[4]) else $error("soft reset read nonzero");

  srst_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rec_srst_done_in && !(wr && idx == `IDX_REC_CONF) |=> !conf_ff.srst)
    else $error("soft reset not cleared");

  loop_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_REC_CONF && wb_sel_in == 4'hF |=> conf_ff[3:0] == $past(wb_dat_in[3:0]))
    else $error("loopback write lost");

  rate_out_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_REC_CONF && wb_sel_in == 4'hF |=> high_rate_clock_mode_out == !$past(wb_dat_in[8]))
    else $error("rate select wrong");

  parc_out_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_REC_CONF && wb_sel_in == 4'hF |=> rec_par_invert_out == $past(wb_dat_in[6]))
    else $error("parity invert wrong");

  // Interrupt status, enable and bus handshake
  irq_sticky_a: assert property (@(posedge clk_in) disable iff (srst_in)
    irq_stat_ff[0] && !(wr && idx == `IDX_IRQ_CLR) |=> irq_stat_ff[0])
    else $error("status bit not sticky");

  irq_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_IRQ_CLR && wb_dat_in[0] && !irq_evt[0] |=> !irq_stat_ff[0])
    else $error("status bit not cleared");

  irq_en_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr && idx == `IDX_IRQ_EN |=> irq_en_ff == $past(wb_dat_in[2:0]))
    else $error("enable write lost");

  unmapped_rd_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rd && idx > `IDX_IRQ_CLR |=> wb_dat_out == 32'h00000000)
    else $error("unmapped read nonzero");

  ack_answer_a: assert property (@(posedge clk_in) disable iff (srst_in)
    req |=> wb_ack_out) else $error("request not acked");

  ack_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");

  // Main scenarios
  read_cov_c: cover property (@(posedge clk_in) rd && idx == `IDX_LCD_STAT && lcd_stat_ff != 0);
  expire_cov_c: cover property (@(posedge clk_in) expire != 8'h00);
  irq_cov_c: cover property (@(posedge clk_in) irq_out);
  srst_cov_c: cover property (@(posedge clk_in) rec_srst_done_in && conf_ff.srst);
  top_cov_c: cover property (@(posedge clk_in) rd && idx == `IDX_TOP_SRC && top_src != 11'h000);

endmodule

// ===== shared/port_regs_regs.svh
`ifndef PORT_REGS_REGS_SVH
`define PORT_REGS_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_THR45      12'h02E
`define IDX_THR67      12'h02F
`define IDX_LCD_STAT   12'h030
`define IDX_LCD_TIMER  12'h031
`define IDX_TOP_SRC    12'h101
`define IDX_TOP_MASK   12'h102
`define IDX_REC_CONF   12'h103
`define IDX_IRQ_STAT   12'h120
`define IDX_IRQ_EN     12'h121
`define IDX_IRQ_CLR    12'h122

// Reset values
`define RST_THR        16'hFFFF
`define RST_LCD_TIMER  16'hFFFF
`define RST_TOP_MASK   11'h7FF
`define RST_INTERNAL_CLOCK_RECOVERY_CIRCUIT_CONF  16'h0020

// Field positions
`define LCD_DIS_BIT    0
`define REC_SRST_BIT   4
`define REC_PDN_BIT    5
`define REC_PARC_BIT   6
`define REC_GIM_BIT    8
`define REC_WMASK      16'h01FF
`define REC_SRST_HIDE  16'h0010

// Thresholds of ports outside this block read as all ones
`define THR_UNUSED     8'hFF

// Port whose timer the reference counter watches
`define LCD_CHK_PORT   2

// Timer scaling: preload is value times 128
`define LCD_SCALE_SH   7
`define LCD_CNT_W      22

`endif

// ===== shared/port_regs_pkg.sv
package port_regs_pkg;

  // Clock recovery configuration fields
  typedef struct packed {
    logic [6:0] unused;
    logic       gim;
    logic       t1_rate_select;
    logic       parc;
    logic       pdn;
    logic       srst;
    logic       lptd;
    logic       lptu;
    logic       lprd;
    logic       lpru;
  } rec_conf_t;

  // Clock recovery error events
  typedef struct packed {
    logic fifo_ovf;
    logic sync_err;
    logic par_err;
  } rec_err_t;

endpackage

// ===== sim/port_regs_test.sv
`timescale 1ns/10ps
`include "port_regs_regs.svh"
module port_regs_test;
  logic                       clk_in, srst_in, cyc, stb, we, irq_out, ack, srst_done;
  logic [13:0]                adr;
  logic [3:0]                 sel;
  logic [31:0]                wdat, rdat, rd;
  logic [7:0]                 lcd_start, lcd_end, lcd_active, src_pend;
  logic [7:0]                 thr [8];
  port_regs_pkg::rec_err_t    err;
  port_regs_pkg::rec_conf_t   conf;
  logic                       rx_en, par_en, par_inv, hi_rate;
  int                         err_count, checked;
  logic [11:0] ridx [8] = '{`IDX_THR45, `IDX_THR67, `IDX_LCD_STAT, `IDX_LCD_TIMER,
                            `IDX_TOP_SRC, `IDX_TOP_MASK, `IDX_REC_CONF, 12'h3FF};
  logic [15:0] rexp [8] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF,
                            16'h0000, 16'h07FF, 16'h0020, 16'h0000};

  port_regs i_port_regs (.clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .lcd_start_in(lcd_start), .lcd_end_in(lcd_end),
    .lcd_active_in(lcd_active), .port_src_pending_in(src_pend), .rec_err_in(err),
    .rec_srst_done_in(srst_done), .thr_port_out(thr), .rec_conf_out(conf),
    .rec_rx_en_out(rx_en), .rec_par_check_en_out(par_en), .rec_par_invert_out(par_inv),
    .high_rate_clock_mode_out(hi_rate), .irq_out(irq_out));

  // Clock source, 20 ns period
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack and read data are taken at the same edge
  task automatic xfer(input logic [11:0] idx, input logic w, input logic [15:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [15:0] exp);
    xfer(idx, 1'b0, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Cut a hang short
  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    srst_in = 1'b1; cyc = 0; stb = 0; we = 0; adr = '0; sel = 4'hF; wdat = '0;
    lcd_start = '0; lcd_end = '0; lcd_active = '0; src_pend = '0; err = '0; srst_done = 0;
    err_count = 0; checked = 0;
    wait_cyc(3);
    srst_in <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(ridx[i], rexp[i]);
    // Threshold bytes land on the right ports
    xfer(`IDX_THR45, 1, 16'h5A3C);
    xfer(`IDX_THR67, 1, 16'h12C4);
    xfer(12'h3FF, 1, 16'hBEEF);
    wait_cyc(2);
    chk({thr[5], thr[4], thr[7], thr[6]}, 32'h5A3C12C4);
    rchk(12'h3FF, 16'h0000);
    xfer(`IDX_TOP_MASK, 1, 16'hFFFF);
    rchk(`IDX_TOP_MASK, 16'h07FF);
    // Delineation start and end flags, cleared by the read
    @(posedge clk_in);
    lcd_start <= 8'h81; lcd_end <= 8'h42;
    @(posedge clk_in);
    lcd_start <= 8'h00; lcd_end <= 8'h00;
    rchk(`IDX_LCD_STAT, 16'h4281);
    rchk(`IDX_LCD_STAT, 16'h0000);
    // Disabled timer never expires, enabled one expires after 128 cycles
    xfer(`IDX_LCD_TIMER, 1, 16'h0003);
    lcd_active <= 8'h04;
    wait_cyc(200);
    rchk(`IDX_LCD_STAT, 16'h0000);
    lcd_active <= 8'h00;
    xfer(`IDX_LCD_TIMER, 1, 16'h0002);
    wait_cyc(2);
    lcd_active <= 8'h04;
    wait_cyc(100);
    rchk(`IDX_LCD_STAT, 16'h0000);
    wait_cyc(60);
    rchk(`IDX_LCD_STAT, 16'h0004);
    lcd_active <= 8'h00;
    // Port summaries follow their sources, reading does not clear
    src_pend <= 8'hA5;
    wait_cyc(3);
    rchk(`IDX_TOP_SRC, 16'h0528);
    rchk(`IDX_TOP_SRC, 16'h0528);
    src_pend <= 8'h00;
    wait_cyc(3);
    rchk(`IDX_TOP_SRC, 16'h0000);
    // Powered down: no errors, no reception
    err <= 3'b111;
    @(posedge clk_in);
    err <= 3'b000;
    wait_cyc(3);
    rchk(`IDX_TOP_SRC, 16'h0000);
    chk({rx_en, par_en}, 0);
    xfer(`IDX_REC_CONF, 1, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      err <= 3'b001 << i;
      @(posedge clk_in);
      err <= 3'b000;
      wait_cyc(3);
      rchk(`IDX_TOP_SRC, 16'h0001 << i);
      rchk(`IDX_TOP_SRC, 16'h0001 << i);
      xfer(`IDX_IRQ_STAT, 0, 16'h0000);
      rchk(`IDX_TOP_SRC, 16'h0000);
    end
    // Interrupt: sticky status, enable and clear
    xfer(`IDX_IRQ_CLR, 1, 16'h0007);
    xfer(`IDX_TOP_MASK, 1, 16'h07FE);
    err <= 3'b001;
    @(posedge clk_in);
    err <= 3'b000;
    wait_cyc(3);
    rchk(`IDX_IRQ_STAT, 16'h0001);
    chk({31'h0, irq_out}, 0);
    xfer(`IDX_IRQ_EN, 1, 16'h0001);
    wait_cyc(3);
    chk({31'h0, irq_out}, 1);
    xfer(`IDX_IRQ_CLR, 1, 16'h0001);
    wait_cyc(3);
    chk({31'h0, irq_out}, 0);
    // Configuration fields, soft reset reads 0 and self-clears
    xfer(`IDX_REC_CONF, 1, 16'h01FF);
    rchk(`IDX_REC_CONF, 16'h01EF);
    chk({conf.srst, conf.lptd, conf.lptu, conf.lprd, conf.lpru}, 5'h1F);
    chk({rx_en, par_en, par_inv, hi_rate}, 4'h2);
    srst_done <= 1'b1;
    @(posedge clk_in);
    srst_done <= 1'b0;
    wait_cyc(2);
    chk({31'h0, conf.srst}, 0);
    xfer(`IDX_REC_CONF, 1, 16'h0005);
    wait_cyc(2);
    chk({conf.lptd, conf.lptu, conf.lprd, conf.lpru}, 4'h5);
    chk({rx_en, par_en, par_inv, hi_rate}, 4'hD);
    stop_test();
  end
endmodule
